// [sfc_defines.svh]
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
// register byte offsets on the bus
`define OFF_INSTR 8'h00
`define OFF_XER 8'h04
`define OFF_CR0 8'h08
`define OFF_STATUS 8'h0C
`define OFF_MASK 8'h10
`define OFF_RESULT 8'h14
`define OFF_GPR_BASE 8'h80
// instruction fields, word bit 31 is instruction bit 0
`define OPCD_HI 31
`define OPCD_LO 26
`define DEST_HI 25
`define DEST_LO 21
`define SUBT_HI 20
`define SUBT_LO 16
`define MINU_HI 15
`define MINU_LO 11
`define OE_POS 10
`define XO_HI 9
`define XO_LO 1
`define REC_POS 0
// decode values
`define PRIMARY_OP 6'h1F
`define XO_CARRYING 9'h008
`define XO_EXTENDED 9'h088
// exception register bit positions
`define XER_CARRY 0
`define XER_OVF 1
`define XER_SO 2
// condition field 0 bit positions
`define CR_NEG 3
`define CR_POS 2
`define CR_ZERO 1
`define CR_SO 0
// status / mask bit positions
`define ST_DONE 0
`define ST_OVF 1
`define ST_ILLEGAL 2
// reset values
`define XER_RESET 3'h0
`define CR0_RESET 4'h0
`define MASK_RESET 3'h0
`endif

// [sfc_pkg.sv]
package sfc_pkg;
    // axi response codes
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } resp_t;
    // decoded operation
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_CARRYING = 2'b01,
        OP_EXTENDED = 2'b10,
        OP_ILLEGAL = 2'b11
    } op_t;
endpackage

// [sub_if.sv]
`timescale 1ns/100ps
`default_nettype none
// operands in, sum and flags out of the adder
interface sub_if;
    logic [31:0] minuend;
    logic [31:0] subtrahend;
    logic cin;
    logic [31:0] sum;
    logic cout;
    logic ovf;
    modport exec (output minuend, output subtrahend, output cin,
                  input sum, input cout, input ovf);
    modport adder (input minuend, input subtrahend, input cin,
                   output sum, output cout, output ovf);
endinterface
`default_nettype wire

// [sub_adder.sv]
`timescale 1ns/100ps
`default_nettype none
// minuend plus inverted subtrahend plus carry in, 33-bit wide
module sub_adder (
    sub_if.adder io
);
    logic [32:0] wide_sum; // carry out in the top bit
    logic [31:0] inv_subt; // ones complement of subtrahend

    assign inv_subt = ~io.subtrahend;
    assign wide_sum = {1'b0, io.minuend} + {1'b0, inv_subt} + {32'h0000_0000, io.cin};
    assign io.sum = wide_sum[31:0];
    assign io.cout = wide_sum[32];
    // signed overflow: like-signed addends, sum sign differs
    assign io.ovf = (io.minuend[31] == inv_subt[31]) && (wide_sum[31] != io.minuend[31]);
endmodule
`default_nettype wire

// [subtract_from_carry_unit.sv]
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defines.svh"
// What this block does
// - op 31/8: minuend plus inverted subtrahend plus one
// - op 31/136: same but plus current carry
// - carry flag always takes sum carry out
// - overflow-enable bit gates overflow, summary flags
// - record bit updates condition field zero
// - signed 32-bit view for overflow, compare
// - dest 6-10, subtrahend 11-15, minuend 16-20
module subtract_from_carry_unit #(
    parameter int NUM_REGS = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output sfc_pkg::resp_t bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output sfc_pkg::resp_t rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq
);
    import sfc_pkg::*;

    // the 5-bit register fields address exactly 32 entries
    if (NUM_REGS != 32) begin : g_chk
        $error("NUM_REGS must be 32");
    end

    // bus slave state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_held_ff, w_held_ff; // address / data latched
    logic [7:0] awaddr_ff; // latched write address
    logic [31:0] wdata_ff; // latched write data
    logic [3:0] wstrb_ff; // latched byte enables
    resp_t bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    // architectural state
    logic [31:0] gpr_ff [NUM_REGS]; // general registers
    logic [31:0] instr_ff; // last instruction word
    logic exec_ff; // one-cycle execute pulse
    logic [2:0] xer_ff; // carry, overflow, summary
    logic [3:0] cr0_ff; // neg, pos, zero, summary
    logic [31:0] result_ff; // last result
    logic [2:0] status_ff; // sticky events
    logic [2:0] mask_ff; // interrupt enables
    logic irq_ff;
    // combinational
    logic do_write; // both halves present
    logic [7:0] wr_addr;
    logic wr_gpr, wr_map_ok;
    logic rd_take, rd_gpr, rd_status;
    logic [31:0] rd_val;
    logic rd_ok;
    op_t op;
    logic [4:0] dest_idx, subt_idx, minu_idx;
    logic oe_bit, rec_bit;
    logic nxt_so;
    logic [2:0] ev;
    sub_if alu ();

    // drive ports straight from flops
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;
    assign irq = irq_ff;

    // field extraction
    assign dest_idx = instr_ff[`DEST_HI:`DEST_LO];
    assign subt_idx = instr_ff[`SUBT_HI:`SUBT_LO];
    assign minu_idx = instr_ff[`MINU_HI:`MINU_LO];
    assign oe_bit = instr_ff[`OE_POS];
    assign rec_bit = instr_ff[`REC_POS];

    // decode of the latched word
    always_comb begin
        if (!exec_ff) begin
            op = OP_NONE;
        end else if (instr_ff[`OPCD_HI:`OPCD_LO] != `PRIMARY_OP) begin
            op = OP_ILLEGAL;
        end else if (instr_ff[`XO_HI:`XO_LO] == `XO_CARRYING) begin
            op = OP_CARRYING;
        end else if (instr_ff[`XO_HI:`XO_LO] == `XO_EXTENDED) begin
            op = OP_EXTENDED;
        end else begin
            op = OP_ILLEGAL;
        end
    end

    // operands to the adder; extended form feeds the carry flag
    assign alu.minuend = gpr_ff[minu_idx];
    assign alu.subtrahend = gpr_ff[subt_idx];
    assign alu.cin = (op == OP_EXTENDED) ? xer_ff[`XER_CARRY] : 1'b1;

    sub_adder u_adder (
        .io(alu.adder)
    );

    // summary flag after this operation, sticky once set
    assign nxt_so = xer_ff[`XER_SO] | (oe_bit & alu.ovf);

    // write channel handshake decode
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_addr = awaddr_ff;
    assign wr_gpr = wr_addr[7];
    assign wr_map_ok = wr_gpr || wr_addr == `OFF_INSTR || wr_addr == `OFF_XER
        || wr_addr == `OFF_MASK;

    // address / data accepted in either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            awready_ff <= !aw_held_ff && !awready_ff && !do_write;
            wready_ff <= !w_held_ff && !wready_ff && !do_write;
            if (awvalid && awready_ff) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
            if (wvalid && wready_ff) begin
                w_held_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // write response, slverr for unmapped or read-only offsets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_map_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // instruction register; a full-word write launches execution
    // partial writes are dropped with an okay response so a half-updated word never runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_ff <= 32'h0000_0000;
            exec_ff <= 1'b0;
        end else begin
            exec_ff <= do_write && wr_addr == `OFF_INSTR && wstrb_ff == 4'hF;
            if (do_write && wr_addr == `OFF_INSTR && wstrb_ff == 4'hF) begin
                instr_ff <= wdata_ff;
            end
        end
    end

    // general registers: bus writes or the destination write
    // no clash: execute lands one cycle after the instruction write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                gpr_ff[i] <= 32'h0000_0000;
            end
        end else if (op == OP_CARRYING || op == OP_EXTENDED) begin
            gpr_ff[dest_idx] <= alu.sum;
        end else if (do_write && wr_gpr) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_ff[b]) begin
                    gpr_ff[wr_addr[6:2]][b*8 +: 8] <= wdata_ff[b*8 +: 8];
                end
            end
        end
    end

    // exception register: carry always, overflow pair only if enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xer_ff <= `XER_RESET;
        end else if (op == OP_CARRYING || op == OP_EXTENDED) begin
            xer_ff[`XER_CARRY] <= alu.cout;
            if (oe_bit) begin
                xer_ff[`XER_OVF] <= alu.ovf;
                xer_ff[`XER_SO] <= nxt_so;
            end
        end else if (do_write && wr_addr == `OFF_XER && wstrb_ff[0]) begin
            xer_ff <= wdata_ff[2:0]; // software may clear summary
        end
    end

    // condition field 0 from signed compare of result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cr0_ff <= `CR0_RESET;
        end else if ((op == OP_CARRYING || op == OP_EXTENDED) && rec_bit) begin
            cr0_ff[`CR_NEG] <= alu.sum[31];
            cr0_ff[`CR_POS] <= !alu.sum[31] && alu.sum != 32'h0000_0000;
            cr0_ff[`CR_ZERO] <= alu.sum == 32'h0000_0000;
            cr0_ff[`CR_SO] <= nxt_so;
        end
    end

    // last result, for software to read back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_ff <= 32'h0000_0000;
        end else if (op == OP_CARRYING || op == OP_EXTENDED) begin
            result_ff <= alu.sum;
        end
    end

    // events: done, overflow seen, illegal word
    assign ev[`ST_DONE] = op == OP_CARRYING || op == OP_EXTENDED;
    assign ev[`ST_OVF] = ev[`ST_DONE] && oe_bit && alu.ovf;
    assign ev[`ST_ILLEGAL] = op == OP_ILLEGAL;

    // read side decode
    assign rd_take = arvalid && arready_ff;
    assign rd_gpr = araddr[7];
    assign rd_status = rd_take && araddr == `OFF_STATUS;
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        if (rd_gpr) begin
            rd_val = gpr_ff[araddr[6:2]];
        end else begin
            case (araddr)
                `OFF_INSTR: rd_val = instr_ff;
                `OFF_XER: rd_val = {29'h0, xer_ff};
                `OFF_CR0: rd_val = {28'h0, cr0_ff};
                `OFF_STATUS: rd_val = {29'h0, status_ff};
                `OFF_MASK: rd_val = {29'h0, mask_ff};
                `OFF_RESULT: rd_val = result_ff;
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // status: read clears, a same-cycle event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= 3'h0;
        end else begin
            status_ff <= (rd_status ? 3'h0 : status_ff) | ev;
        end
    end

    // interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_ff <= `MASK_RESET;
        end else if (do_write && wr_addr == `OFF_MASK && wstrb_ff[0]) begin
            mask_ff <= wdata_ff[2:0];
        end
    end

    // level interrupt, one cycle behind status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // read channel: one read at a time, data one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else begin
            arready_ff <= !arready_ff && !rvalid_ff;
            if (rd_take) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_val;
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // checks
    logic exec_op;
    assign exec_op = op == OP_CARRYING || op == OP_EXTENDED;

    carry_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_op |=> result_ff == $past(alu.sum)
            && xer_ff[`XER_CARRY] == $past(alu.cout))
        else $error("carry or result not taken from sum");
    plain_form_a: assert property (@(posedge aclk) disable iff (!aresetn)
        op == OP_CARRYING |-> alu.sum == alu.minuend + ~alu.subtrahend + 32'h1)
        else $error("carrying form sum wrong");
    ext_form_a: assert property (@(posedge aclk) disable iff (!aresetn)
        op == OP_EXTENDED |-> alu.sum == alu.minuend + ~alu.subtrahend
            + {31'h0, xer_ff[`XER_CARRY]})
        else $error("extended form sum wrong");
    ovf_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_op && !oe_bit |=> $stable(xer_ff[2:1]))
        else $error("overflow flags moved without enable");
    ovf_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_op && oe_bit |=> xer_ff[`XER_OVF] == $past(alu.ovf)
            && xer_ff[`XER_SO] == ($past(xer_ff[`XER_SO]) || $past(alu.ovf)))
        else $error("overflow not tracked");
    cr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_op && !rec_bit |=> $stable(cr0_ff))
        else $error("condition field moved without record");
    cr_sign_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_op && rec_bit |=> cr0_ff[3:1] == ($signed(result_ff) < 0 ? 3'h4
            : result_ff == 32'h0 ? 3'h1 : 3'h2)
            && cr0_ff[`CR_SO] == xer_ff[`XER_SO])
        else $error("condition field wrong");
    dest_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_op |=> gpr_ff[$past(dest_idx)] == $past(alu.sum))
        else $error("destination not written");
    instr_exec_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && wr_addr == `OFF_INSTR && wstrb_ff == 4'hF |=> exec_ff ##1 !exec_ff)
        else $error("execute pulse wrong");
    cover_ext_c: cover property (@(posedge aclk) op == OP_EXTENDED && oe_bit && rec_bit);
    cover_ovf_c: cover property (@(posedge aclk) ev[`ST_OVF]);
    cover_irq_c: cover property (@(posedge aclk) $rose(irq_ff));
endmodule
`default_nettype wire

// [tb_subtract_from_carry_unit.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defines.svh"
// register-level bench: loads operands, executes words, checks flags
module tb_subtract_from_carry_unit;
    import sfc_pkg::*;
    // one operand set per executed word
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
        logic oe;
        logic rec;
        logic ext;
        logic xw;
        logic [2:0] xv;
    } case_t;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    wire logic awready, wready, bvalid, arready, rvalid, irq;
    wire logic [31:0] rdata;
    resp_t bresp, rresp;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    logic [2:0] xer_m = 3'h0; // expected carry, overflow, summary
    logic [3:0] cr_m = 4'h0; // expected condition field zero
    // operand table: subtrahend, minuend, oe, rc, extended, xer preset
    case_t tbl [10] = '{
        '{32'h8000_7000, 32'h9000_3000, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0},
        '{32'h0000_4500, 32'h8000_7000, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0},
        '{32'h8000_0000, 32'h0000_4500, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0},
        '{32'h8000_0000, 32'h0000_7000, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0},
        '{32'h0000_0005, 32'h0000_0005, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0},
        '{32'h9000_3000, 32'h8000_7000, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1},
        '{32'h0000_4500, 32'h8000_7000, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0},
        '{32'h8000_0000, 32'hEFFF_FFFF, 1'b1, 1'b0, 1'b1, 1'b1, 3'h1},
        '{32'h8000_0000, 32'hEFFF_FFFF, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0},
        '{32'h0000_0001, 32'h0000_0001, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0}};
    subtract_from_carry_unit dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq)
    );
    // 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // compare helpers, one per kind of result
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected word at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input resp_t got, input resp_t exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected response at %0t: got %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected irq at %0t: got %b want %b", $time, got, exp);
        end
    endtask
    // bus write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output resp_t r);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    // bus read: rready held until the data is seen
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output resp_t r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    // instruction word builder
    function automatic logic [31:0] ins(input logic [4:0] d, input logic [4:0] s,
                                        input logic [4:0] m, input logic oe,
                                        input logic [8:0] xo, input logic rec);
        ins = {`PRIMARY_OP, d, s, m, oe, xo, rec};
    endfunction
    // load operands, execute one table entry, check result and flags
    task automatic run_case(input int i);
        case_t c;
        logic [32:0] w;
        logic [31:0] res, got;
        logic [4:0] dst;
        logic ovf;
        resp_t rs;
        c = tbl[i];
        dst = 5'h10 + i[4:0];
        if (c.xw) begin
            axw(`OFF_XER, {29'h0, c.xv}, 4'hF, rs);
            xer_m = c.xv;
        end
        axw(8'h90, c.a, 4'hF, rs);
        axw(8'hA8, c.b, 4'hF, rs);
        axw(`OFF_INSTR, ins(dst, 5'h04, 5'h0A, c.oe, c.ext ? `XO_EXTENDED : `XO_CARRYING,
            c.rec), 4'hF, rs);
        // reference sum, carry in is one or the current carry
        w = {1'b0, c.b} + {1'b0, ~c.a} + {32'h0, c.ext ? xer_m[0] : 1'b1};
        res = w[31:0];
        // signed difference overflows when operand signs differ and the sign flips
        ovf = (c.b[31] != c.a[31]) && (res[31] != c.b[31]);
        xer_m[0] = w[32];
        if (c.oe) begin
            xer_m[1] = ovf;
            xer_m[2] = xer_m[2] | ovf;
        end
        if (c.rec) cr_m = {res[31], !res[31] && (res != 32'h0), res == 32'h0, xer_m[2]};
        axr(8'h80 + {1'b0, dst, 2'b00}, got, rs);
        chk_word(got, res);
        axr(`OFF_RESULT, got, rs);
        chk_word(got, res);
        axr(`OFF_XER, got, rs);
        chk_word(got, {29'h0, xer_m});
        axr(`OFF_CR0, got, rs);
        chk_word(got, {28'h0, cr_m});
        axr(`OFF_STATUS, got, rs);
        chk_word(got & 32'h5, 32'h1);
    endtask
    // verdict, called from the main sequence and from the watchdog
    task automatic end_of_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog: whole run needs a few hundred cycles
    initial begin
        while (cyc < 20000) begin
            @(posedge aclk);
            cyc++;
        end
        fail_count++;
        $display("unexpected timeout at %0t", $time);
        end_of_test();
    end
    // main sequence
    initial begin
        logic [31:0] d;
        resp_t rs;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values
        axr(`OFF_XER, d, rs);
        chk_word(d, 32'h0);
        axr(`OFF_MASK, d, rs);
        chk_word(d, 32'h0);
        chk_bit(irq, 1'b0);
        // byte strobes on a general register
        axw(8'hFC, 32'hFFFF_FFFF, 4'hF, rs);
        axw(8'hFC, 32'h0000_00AB, 4'h1, rs);
        axr(8'hFC, d, rs);
        chk_word(d, 32'hFFFF_FFAB);
        for (int i = 0; i < 10; i++) run_case(i);
        // undecoded word raises the illegal event, masked in
        axw(`OFF_MASK, 32'h4, 4'hF, rs);
        axw(`OFF_INSTR, ins(5'd30, 5'd4, 5'd10, 1'b1, 9'h028, 1'b1), 4'hF, rs);
        repeat (4) @(posedge aclk);
        chk_bit(irq, 1'b1);
        axr(`OFF_STATUS, d, rs);
        chk_word(d & 32'h5, 32'h4);
        repeat (3) @(posedge aclk);
        chk_bit(irq, 1'b0);
        axr(8'hF8, d, rs);
        chk_word(d, 32'h0);
        axr(`OFF_XER, d, rs);
        chk_word(d, {29'h0, xer_m});
        // same event with the mask cleared keeps irq low
        axw(`OFF_MASK, 32'h0, 4'hF, rs);
        axw(`OFF_INSTR, {6'h1E, 26'h0}, 4'hF, rs);
        repeat (4) @(posedge aclk);
        chk_bit(irq, 1'b0);
        axr(`OFF_STATUS, d, rs);
        chk_word(d & 32'h5, 32'h4);
        // partial write of the instruction word does not execute
        axw(`OFF_INSTR, ins(5'd1, 5'd4, 5'd10, 1'b0, `XO_CARRYING, 1'b0), 4'h3, rs);
        axr(`OFF_STATUS, d, rs);
        chk_word(d, 32'h0);
        // refused accesses
        axr(8'h40, d, rs);
        chk_resp(rs, RESP_SLVERR);
        chk_word(d, 32'h0);
        axw(`OFF_CR0, 32'hF, 4'hF, rs);
        chk_resp(rs, RESP_SLVERR);
        axr(`OFF_CR0, d, rs);
        chk_word(d, {28'h0, cr_m});
        end_of_test();
    end
endmodule
`default_nettype wire
